// File: hdl/tw_pkg.sv
package tw_pkg;
	// register indices; byte address is four times the index
	localparam int IDX_W = 8;
	localparam logic [IDX_W-1:0] IDX_CTRL = 8'ha0;
	localparam logic [IDX_W-1:0] IDX_STAT = 8'ha1;
	localparam logic [IDX_W-1:0] IDX_DATA = 8'ha2;
	localparam logic [IDX_W-1:0] IDX_SAR = 8'ha3;
	localparam logic [IDX_W-1:0] IDX_MODE = 8'ha4;
	localparam logic [IDX_W-1:0] IDX_XCTL = 8'ha5;
	localparam logic [IDX_W-1:0] IDX_IRQ = 8'ha6;
	localparam logic [IDX_W-1:0] IDX_MASK = 8'ha7;
	localparam int ADDR_LO = 2;
	localparam int ADDR_HI = ADDR_LO + IDX_W - 1;

	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_SAR = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MODE_RSVD = 8'h38;

	// field positions
	localparam int SAR_FS = 0;
	localparam int XCTL_EXT = 0;
	localparam int MODE_BC_W = 3;
	localparam int FLG_ADDR = 6;
	localparam int FLG_DONE = 3;
	localparam int FLG_NACK = 2;
	localparam int FLG_START = 1;
	localparam logic [7:0] FLG_MASK = 8'h4e;

	// frame geometry
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] FRAME_BITS = 4'h8;
	localparam int SEL_W = 4;

	// serial clock divisors indexed by {extension, clock field}
	localparam logic [8:0] DIV_TAB [16] = '{
		9'h01c, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080,
		9'h038, 9'h050, 9'h060, 9'h080, 9'h0a0, 9'h0c8, 9'h0e0, 9'h100
	};

	typedef struct packed {
		logic en;
		logic ie;
		logic role;
		logic dir;
		logic plain;
		logic [2:0] cks;
	} tw_ctl_t;

	typedef enum logic [2:0] {
		TW_IDLE = 3'b001,
		TW_ADDR = 3'b010,
		TW_XFER = 3'b100
	} tw_state_t;
endpackage

// File: hdl/tw_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module tw_clk_div #(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// control
	input wire logic run_in,
	input wire logic [tw_pkg::SEL_W-1:0] sel_in,
	// half period strobe
	output logic tick_out
);
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] half;
	logic [DIV_W-1:0] gap;
	logic seen;
	logic [8:0] div_sel;

	assign div_sel = tw_pkg::DIV_TAB[sel_in];
	assign half = DIV_W'(div_sel >> 1);

	// counter restarts with each frame so the first low half is full length
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else if (!run_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else if (cnt == half - 1'b1) begin
			cnt <= '0;
			tick_out <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gap <= '0;
			seen <= 1'b0;
		end else if (!run_in || $changed(sel_in)) begin
			gap <= '0;
			seen <= 1'b0;
		end else if (tick_out) begin
			gap <= DIV_W'(1);
			seen <= 1'b1;
		end else begin
			gap <= gap + 1'b1;
		end
	end

	half_period_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		tick_out && run_in && seen && $stable(sel_in) |-> gap == half)
		else $error("serial clock half period wrong");
endmodule
`default_nettype wire

// File: hdl/tw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tw_ctrl #(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// two-wire bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// interrupt
	output logic irq_out
);
	logic [7:0] ctrl;
	logic [7:0] own_slave_address;
	logic [7:0] xctl;
	logic [tw_pkg::MODE_BC_W-1:0] bc;
	logic [7:0] stat;
	logic [7:0] irq_stat;
	logic [7:0] irq_mask;
	logic [7:0] data;
	logic [7:0] shift;
	logic [tw_pkg::CNT_W-1:0] bit_cnt;
	logic [tw_pkg::CNT_W-1:0] rise_total;
	logic busy;
	logic phase;
	logic scl_d;
	logic sda_d;
	logic wr_pend;
	logic [tw_pkg::IDX_W-1:0] wr_idx;
	tw_pkg::tw_state_t state;
	tw_pkg::tw_ctl_t ctl;

	// bus decode
	wire ahb_take = hsel_in && hready_in && htrans_in[1];
	wire hi_zero = (haddr_in[31:tw_pkg::ADDR_HI+1] == '0) && (haddr_in[1:0] == 2'h0);
	wire [tw_pkg::IDX_W-1:0] rd_idx = haddr_in[tw_pkg::ADDR_HI:tw_pkg::ADDR_LO];
	wire rd_take = ahb_take && !hwrite_in && hi_zero;
	wire stat_wr = wr_pend && (wr_idx == tw_pkg::IDX_STAT);
	wire data_wr = wr_pend && (wr_idx == tw_pkg::IDX_DATA);
	wire irq_rd = rd_take && (rd_idx == tw_pkg::IDX_IRQ);
	wire [7:0] wdata = hwdata_in[7:0];
	wire [7:0] mode_rd = tw_pkg::MODE_RSVD | {5'h00, bc};
	// unmapped addresses read zero and ignore writes
	wire [7:0] rd_val =
		(rd_idx == tw_pkg::IDX_CTRL) ? ctrl :
		(rd_idx == tw_pkg::IDX_STAT) ? stat :
		(rd_idx == tw_pkg::IDX_DATA) ? data :
		(rd_idx == tw_pkg::IDX_SAR) ? own_slave_address :
		(rd_idx == tw_pkg::IDX_MODE) ? mode_rd :
		(rd_idx == tw_pkg::IDX_XCTL) ? xctl :
		(rd_idx == tw_pkg::IDX_IRQ) ? irq_stat :
		(rd_idx == tw_pkg::IDX_MASK) ? irq_mask : tw_pkg::RST_ZERO;

	assign ctl = ctrl;

	// frame geometry
	wire plain = ctl.plain;
	wire fs = own_slave_address[tw_pkg::SAR_FS];
	wire [tw_pkg::CNT_W-1:0] data_bits = (bc == '0) ? tw_pkg::FRAME_BITS
		: {1'b0, bc};
	wire [tw_pkg::CNT_W-1:0] cur_bits = (state == tw_pkg::TW_ADDR) ? tw_pkg::FRAME_BITS
		: data_bits;
	wire [tw_pkg::CNT_W-1:0] frame_len = cur_bits + {3'h0, !plain};

	// mode decode
	wire is_master = ctl.en && ctl.role;
	wire is_slave = ctl.en && !ctl.role;
	wire transmit = ctl.dir;

	// serial clock events
	logic tick;
	wire m_start = is_master && data_wr && (state == tw_pkg::TW_IDLE);
	wire m_rise = busy && tick && !phase;
	wire m_fall = m_start || (busy && tick && phase);
	wire s_active = is_slave && (state != tw_pkg::TW_IDLE);
	wire s_rise = s_active && scl_in && !scl_d;
	wire s_fall = s_active && !scl_in && scl_d;
	wire start_det = is_slave && scl_d && scl_in && sda_d && !sda_in;
	wire rise_ev = m_rise || s_rise;
	wire fall_ev = m_fall || s_fall;
	wire data_phase = bit_cnt < cur_bits;
	wire last_bit = rise_ev && (bit_cnt + 1'b1 == frame_len);
	wire [7:0] next_shift = {shift[6:0], sda_in};
	wire [7:0] rx_byte = data_phase ? next_shift : shift;
	wire addr_hit = (rx_byte[7:1] == own_slave_address[7:1]) && !fs;
	wire in_xfer = (state == tw_pkg::TW_XFER);
	wire rx_load = last_bit && in_xfer && !transmit;

	// data line drive at each falling clock edge
	wire ack_pos = !plain && (bit_cnt == cur_bits);
	// at the master start the byte is still on the write bus, not yet in the register
	wire tx_frame = in_xfer || m_start;
	wire tx_bit = m_start ? wdata[7] : (bit_cnt == '0) ? data[7] : shift[7];
	wire tx_drive = tx_frame && transmit && data_phase && !tx_bit;
	wire ack_drive = ack_pos && ((state == tw_pkg::TW_ADDR) ? addr_hit
		: (in_xfer && !transmit));
	wire next_sda_low = !ctl.en ? 1'b0 :
		fall_ev ? (tx_drive || ack_drive) :
		(last_bit && ctl.role) ? 1'b0 :
		start_det ? 1'b0 : sda_oe_out;

	// master clock sequencing; a role change aborts the frame
	wire next_busy = (!is_master) ? 1'b0 : m_start ? 1'b1
		: (m_rise && last_bit) ? 1'b0 : busy;
	wire next_phase = m_start ? 1'b0 : (busy && tick) ? !phase : phase;
	wire next_scl_low = ctl.en && next_busy && !next_phase;

	// flag events
	logic [7:0] flag_set;
	always_comb begin
		flag_set = tw_pkg::RST_ZERO;
		flag_set[tw_pkg::FLG_START] = start_det;
		flag_set[tw_pkg::FLG_ADDR] = last_bit && (state == tw_pkg::TW_ADDR) && addr_hit;
		flag_set[tw_pkg::FLG_DONE] = last_bit && in_xfer;
		flag_set[tw_pkg::FLG_NACK] = last_bit && in_xfer && transmit && !plain && sda_in;
	end
	// a hardware set in the clearing cycle wins over the clear
	wire [7:0] next_stat = ((stat_wr ? (stat & wdata) : stat) | flag_set)
		& tw_pkg::FLG_MASK;
	wire [7:0] next_irq_stat = ((irq_rd ? tw_pkg::RST_ZERO : irq_stat) | flag_set)
		& tw_pkg::FLG_MASK;
	wire next_irq = ctl.ie && |(next_irq_stat & irq_mask);

	// state sequencing
	tw_pkg::tw_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			tw_pkg::TW_IDLE: begin
				if (m_start) begin
					next_state = tw_pkg::TW_XFER;
				end else if (start_det) begin
					next_state = fs ? tw_pkg::TW_XFER : tw_pkg::TW_ADDR;
				end
			end
			tw_pkg::TW_ADDR: begin
				if (start_det) begin
					next_state = tw_pkg::TW_ADDR;
				end else if (last_bit) begin
					next_state = addr_hit ? tw_pkg::TW_XFER : tw_pkg::TW_IDLE;
				end
			end
			tw_pkg::TW_XFER: begin
				if (start_det) begin
					next_state = fs ? tw_pkg::TW_XFER : tw_pkg::TW_ADDR;
				end else if (last_bit && ctl.role) begin
					next_state = tw_pkg::TW_IDLE;
				end
			end
			default: next_state = tw_pkg::TW_IDLE;
		endcase
		if (!ctl.en) begin
			next_state = tw_pkg::TW_IDLE;
		end
	end

	tw_clk_div #(
		.DIV_W(DIV_W)
	) u_div (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.run_in(busy),
		.sel_in({xctl[tw_pkg::XCTL_EXT], ctl.cks}),
		.tick_out(tick)
	);

	// bus slave: zero wait, read data registered in the address phase
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hrdata_out <= '0;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			wr_pend <= 1'b0;
			wr_idx <= '0;
		end else begin
			hrdata_out <= rd_take ? {24'h000000, rd_val} : '0;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			wr_pend <= ahb_take && hwrite_in && hi_zero;
			wr_idx <= rd_idx;
		end
	end

	// software registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl <= tw_pkg::RST_CTRL;
			own_slave_address <= tw_pkg::RST_SAR;
			xctl <= tw_pkg::RST_ZERO;
			bc <= '0;
			irq_mask <= tw_pkg::RST_ZERO;
		end else if (wr_pend) begin
			if (wr_idx == tw_pkg::IDX_CTRL) ctrl <= wdata;
			if (wr_idx == tw_pkg::IDX_SAR) own_slave_address <= wdata;
			if (wr_idx == tw_pkg::IDX_XCTL) xctl <= wdata & 8'h01;
			if (wr_idx == tw_pkg::IDX_MODE) bc <= wdata[tw_pkg::MODE_BC_W-1:0];
			if (wr_idx == tw_pkg::IDX_MASK) irq_mask <= wdata & tw_pkg::FLG_MASK;
		end
	end

	// flags and interrupt
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat <= tw_pkg::RST_ZERO;
			irq_stat <= tw_pkg::RST_ZERO;
			irq_out <= 1'b0;
		end else begin
			stat <= next_stat;
			irq_stat <= next_irq_stat;
			irq_out <= next_irq;
		end
	end

	// data byte has no reset value; the receive load wins over a bus write
	always_ff @(posedge clk_in) begin
		if (rx_load) begin
			data <= rx_byte;
		end else if (data_wr) begin
			data <= wdata;
		end
	end

	// serial engine
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= tw_pkg::TW_IDLE;
			bit_cnt <= '0;
			shift <= '0;
			busy <= 1'b0;
			phase <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			state <= next_state;
			busy <= next_busy;
			phase <= next_phase;
			scl_d <= scl_in;
			sda_d <= sda_in;
			if (m_start || start_det || last_bit || !ctl.en) begin
				bit_cnt <= '0;
			end else if (rise_ev) begin
				bit_cnt <= bit_cnt + 1'b1;
			end
			// whole byte loaded: each rise shifts the next bit to the top
			if (m_start) begin
				shift <= wdata;
			end else if (fall_ev && transmit && in_xfer && bit_cnt == '0) begin
				shift <= data;
			end else if (rise_ev && data_phase) begin
				shift <= next_shift;
			end
		end
	end

	// pins: open drain, only ever pulled low
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe_out <= next_scl_low;
			sda_oe_out <= next_sda_low;
		end
	end

	// checking helpers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rise_total <= '0;
		end else if (m_start) begin
			rise_total <= '0;
		end else if (m_rise) begin
			rise_total <= rise_total + 1'b1;
		end
	end
	wire [tw_pkg::CNT_W-1:0] exp_len = ((bc == '0) ? 4'h8 : {1'b0, bc}) + (plain ? 4'h0 : 4'h1);

	sequence data_read_s;
		rd_take && (rd_idx == tw_pkg::IDX_DATA);
	endsequence
	sequence stat_clear_s;
		stat_wr && (flag_set == '0);
	endsequence

	lines_released_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$past(!ctl.en) |-> !scl_oe_out && !sda_oe_out)
		else $error("bus lines driven while disabled");
	clock_driven_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		busy && !phase && ctl.en |-> scl_oe_out)
		else $error("serial clock not driven in low half");
	slave_clock_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$past(!ctl.role) |-> !scl_oe_out)
		else $error("slave drove the serial clock");
	tx_first_bit_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		fall_ev && ctl.en && transmit && (in_xfer || m_start) && bit_cnt == '0
		|=> sda_oe_out == !$past(m_start ? wdata[7] : data[7]))
		else $error("first transmit bit wrong");
	irq_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$past(!ctl.ie) |-> !irq_out)
		else $error("interrupt raised while disabled");
	frame_length_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$fell(busy) && $past(is_master) && $stable(ctrl) |-> rise_total == exp_len)
		else $error("frame length wrong");
	ack_framing_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$fell(busy) && $past(is_master) && $past(plain) |-> rise_total <= tw_pkg::FRAME_BITS)
		else $error("plain framing added a bit");
	flag_write_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		stat_clear_s |=> stat == ($past(stat) & $past(wdata)))
		else $error("status write not clear-only");
	addr_match_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(stat[tw_pkg::FLG_ADDR]) |-> $past(addr_hit && state == tw_pkg::TW_ADDR))
		else $error("address flag without own address");
	data_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		data_wr && !rx_load ##2 data_read_s |=> hrdata_out[7:0] == $past(wdata, 3))
		else $error("data byte read back wrong");
endmodule
`default_nettype wire

// File: test/tw_peer.sv
`timescale 1ns/1ps
`default_nettype none
module tw_peer (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// bus lines and frame setup
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic clr_in,
	input wire logic ack_in,
	input wire logic [3:0] bits_in,
	// pull-down and captured byte
	output logic sda_oe_out,
	output logic [7:0] byte_out
);
	logic scl_q;
	logic [3:0] cnt;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_q <= 1'b1;
			cnt <= 4'h0;
			sda_oe_out <= 1'b0;
			byte_out <= 8'h00;
		end else begin
			scl_q <= scl_in;
			if (clr_in) begin
				cnt <= 4'h0;
				sda_oe_out <= 1'b0;
			end else if (scl_in && !scl_q) begin
				cnt <= cnt + 4'h1;
				// msb first, sampled on the clock rise
				if (cnt < bits_in) begin
					byte_out <= {byte_out[6:0], sda_in};
				end
			end else if (!scl_in && scl_q) begin
				// ack held past the rise so the master samples it settled
				sda_oe_out <= ack_in && (cnt == bits_in);
			end
		end
	end
endmodule
`default_nettype wire

// File: test/test_two_wire_bus_interface_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_bus_interface_control;
	logic clk_in = 1'b0;
	logic arst_n_in, hsel_in, hwrite_in, scl_oe, sda_oe, scl_o, sda_o, irq_o, hresp, hrdy;
	logic [1:0] htrans_in;
	logic [31:0] haddr_in, hwdata_in, hrdata;
	logic p_oe, clr_in, ack_in, scl_w, sda_w, scl_q, rph, b_scl, b_sda;
	logic [3:0] bits_in;
	logic [7:0] p_byte, rdv, ce, cm, v;
	logic [7:0] eq[$];
	logic [7:0] mq[$];
	logic [15:0] rises, per;
	logic [31:0] cyc, t1, seed;
	int num_errors, tests_run, i;
	assign scl_w = !(scl_oe || b_scl);
	assign sda_w = !(sda_oe || p_oe || b_sda);
	always #5 clk_in = ~clk_in;
	tw_ctrl #(.DIV_W(8)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
		.hwdata_in(hwdata_in), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
		.sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq_o));
	tw_peer peer (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl_w), .sda_in(sda_w),
		.clr_in(clr_in), .ack_in(ack_in), .bits_in(bits_in), .sda_oe_out(p_oe),
		.byte_out(p_byte));
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		tests_run++;
		if ((got & m) !== exp) begin
			num_errors++;
			$display("wrong value at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write data or expected read value in d; the monitor checks reads
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'b10;
		haddr_in <= {22'h0, a, 2'b00};
		hwrite_in <= w;
		if (!w) begin
			eq.push_back(d);
			mq.push_back(m);
		end
		do @(posedge clk_in); while (hrdy !== 1'b1);
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= {24'h0, d};
		do @(posedge clk_in); while (hrdy !== 1'b1);
		rdv = hrdata[7:0];
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 8'h00);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		bus(1'b0, a, e, m);
	endtask
	always @(posedge clk_in) begin
		if (rph && hrdy === 1'b1) begin
			ce = eq.pop_front();
			cm = mq.pop_front();
			cmp_rd(hrdata, {24'h0, ce & cm}, {24'hffffff, cm});
		end
		rph = hsel_in && htrans_in[1] && hrdy && !hwrite_in;
		cyc = cyc + 1;
		if (clr_in) begin
			rises = 16'h0;
		end else if (scl_w && !scl_q) begin
			rises = rises + 16'h1;
			if (rises == 16'h1) t1 = cyc;
			if (rises == 16'h2) per = 16'(cyc - t1);
		end
		scl_q = scl_w;
		// longest run is about 20000 cycles
		if (cyc > 100000) begin
			num_errors++;
			finish_test;
		end
	end
	task frame(input logic e, input logic [2:0] k, input logic [2:0] b, input logic p,
		input logic a, input logic t, input logic ie, input logic ei);
		logic [7:0] d, s, m;
		logic [3:0] nb;
		int n;
		d = 8'($random(seed));
		nb = (b == 3'h0) ? 4'h8 : {1'b0, b};
		s = {4'h0, 1'b1, !a && !p && t, 2'b00};
		m = (p || !t) ? 8'h08 : 8'h0c;
		bits_in <= nb;
		ack_in <= a && !p && t;
		clr_in <= 1'b1;
		@(posedge clk_in);
		clr_in <= 1'b0;
		wr(tw_pkg::IDX_XCTL, {7'h0, e});
		wr(tw_pkg::IDX_MODE, {5'h0, b});
		wr(tw_pkg::IDX_CTRL, {1'b1, ie, 1'b1, t, p, k});
		wr(tw_pkg::IDX_DATA, d);
		n = 0;
		rdv = 8'h00;
		while (rdv[3] !== 1'b1 && n < 3000) begin
			rd(tw_pkg::IDX_STAT, 8'h00, 8'h00);
			n++;
		end
		cmp(rises, {12'h0, nb} + {15'h0, !p});
		if (b == 3'h0) cmp(per, {7'h0, tw_pkg::DIV_TAB[{e, k}]});
		if (b == 3'h0 && t) cmp({8'h0, p_byte}, {8'h0, d});
		if (!t) rd(tw_pkg::IDX_DATA, 8'hff, 8'hff);
		repeat (2) @(posedge clk_in);
		cmp({15'h0, irq_o}, {15'h0, ei});
		rd(tw_pkg::IDX_STAT, s, m);
		wr(tw_pkg::IDX_STAT, 8'hff);
		rd(tw_pkg::IDX_STAT, s, m);
		wr(tw_pkg::IDX_STAT, 8'h00);
		rd(tw_pkg::IDX_STAT, 8'h00, 8'h4e);
		rd(tw_pkg::IDX_IRQ, 8'h08, 8'h08);
		repeat (2) @(posedge clk_in);
		cmp({15'h0, irq_o}, 16'h0);
		cmp({13'h0, hresp, scl_o, sda_o}, 16'h0);
	endtask
	// bench as bus master: start, seven address bits, read bit, then the ack clock
	task slave_addr(input logic [6:0] a, input logic hit);
		logic ack;
		int j;
		clr_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		b_sda <= 1'b1;
		repeat (4) @(posedge clk_in);
		for (j = 0; j < 9; j++) begin
			b_scl <= 1'b1;
			repeat (4) @(posedge clk_in);
			b_sda <= (j < 7) ? !a[6-j] : 1'b0;
			repeat (4) @(posedge clk_in);
			b_scl <= 1'b0;
			repeat (4) @(posedge clk_in);
			ack = sda_oe;
		end
		clr_in <= 1'b0;
		cmp({15'h0, ack}, {15'h0, hit});
		rd(tw_pkg::IDX_STAT, {1'b0, hit, 4'h0, 1'b1, 1'b0}, 8'h42);
		wr(tw_pkg::IDX_STAT, 8'h00);
	endtask
	initial begin
		seed = 32'haac77ded;
		{hsel_in, hwrite_in, clr_in, ack_in, scl_q, rph, b_scl, b_sda} = 8'h0;
		htrans_in = 2'b00;
		haddr_in = 32'h0;
		hwdata_in = 32'h0;
		bits_in = 4'h8;
		rises = 16'h0;
		per = 16'h0;
		cyc = 32'h0;
		t1 = 32'h0;
		arst_n_in = 1'b0;
		repeat (10) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rd(tw_pkg::IDX_CTRL, tw_pkg::RST_CTRL, 8'hff);
		rd(tw_pkg::IDX_SAR, tw_pkg::RST_SAR, 8'hff);
		rd(tw_pkg::IDX_MODE, tw_pkg::MODE_RSVD, 8'hff);
		rd(tw_pkg::IDX_STAT, tw_pkg::RST_ZERO, 8'hff);
		rd(8'h10, 8'h00, 8'hff);
		wr(tw_pkg::IDX_STAT, 8'hff);
		rd(tw_pkg::IDX_STAT, tw_pkg::RST_ZERO, 8'hff);
		v = 8'($random(seed));
		wr(tw_pkg::IDX_SAR, v);
		rd(tw_pkg::IDX_SAR, v, 8'hff);
		wr(tw_pkg::IDX_DATA, ~v);
		rd(tw_pkg::IDX_DATA, ~v, 8'hff);
		cmp({14'h0, scl_oe, sda_oe}, 16'h0);
		// a set mask bit lets its status bit reach the interrupt
		wr(tw_pkg::IDX_MASK, tw_pkg::FLG_MASK);
		for (i = 0; i < 16; i++) begin
			frame(i[3], i[2:0], 3'h0, 1'b0, i[0], 1'b1, i[1], i[1]);
		end
		for (i = 0; i < 8; i++) begin
			frame(1'b0, 3'h0, i[2:0], i[1], 1'b1, 1'b1, 1'b1, 1'b1);
		end
		frame(1'b0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(tw_pkg::IDX_SAR, {v[7:1], 1'b0});
		wr(tw_pkg::IDX_CTRL, 8'h80);
		slave_addr(~v[7:1], 1'b0);
		slave_addr(v[7:1], 1'b1);
		wr(tw_pkg::IDX_CTRL, 8'h00);
		wr(tw_pkg::IDX_MASK, 8'h00);
		frame(1'b0, 3'h1, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		// disable in mid-frame, during the clock high half, must drop the data pull at once
		wr(tw_pkg::IDX_CTRL, 8'hf7);
		wr(tw_pkg::IDX_DATA, 8'h3c);
		repeat (100) @(posedge clk_in);
		wr(tw_pkg::IDX_CTRL, 8'h00);
		repeat (2) @(posedge clk_in);
		cmp({14'h0, scl_oe, sda_oe}, 16'h0);
		finish_test;
	end
endmodule
`default_nettype wire
